/* src/tif_regs.svh */
// Register offsets, field positions and defaults of the tag event block
// Included by the package-aware design files and by the assertion module
`ifndef TIF_REGS_SVH
`define TIF_REGS_SVH

`define TIF_ADDR_MASK_LOW 8'h08
`define TIF_ADDR_MASK_HIGH 8'h09
`define TIF_ADDR_FLAGS_LOW 8'h0A
`define TIF_ADDR_FLAGS_HIGH 8'h0B

`define TIF_FLAGS_RESET 8'h00
`define TIF_MASK_RESET 8'hFF

`define TIF_BIT_POWERUP 7
`define TIF_BIT_WAKEUP 6
`define TIF_BIT_SLEEP 5
`define TIF_BIT_RD_WROTE 4
`define TIF_BIT_RD_READ 3
`define TIF_BIT_RX_END 2
`define TIF_BIT_TX_END 1
`define TIF_BIT_FIELD_EXIT 0

`define TIF_BIT_RX_START 7
`define TIF_BIT_FRAMING 6
`define TIF_BIT_PARITY 5
`define TIF_BIT_CHECKSUM 4
`define TIF_BIT_BUF_FAULT 3
`define TIF_BIT_HOST_EEWR 2
`define TIF_BIT_EE_ACCESS 1
`define TIF_BIT_ACC_ABORT 0

`endif

/* src/tif_pkg.sv */
// Types shared by the tag event block
// Assumes the register header is included alongside
package tif_pkg;
    typedef logic [7:0] tif_byte_t;
    typedef logic [15:0] tif_events_t;
    typedef enum logic [1:0] {
        TIF_LOAD_WAIT = 2'b00,
        TIF_LOAD_RUN = 2'b01
    } tif_load_t;
endpackage

/* src/tif_reg_if.sv */
// Register access group between the top and the flag bank
// Assumes one clock domain
`timescale 1ns/1ps
interface tif_reg_if;
    logic rd_en;
    logic wr_en;
    logic [7:0] addr;
    logic [7:0] wdata;
    modport bank (input rd_en, input wr_en, input addr, input wdata);
    modport host (output rd_en, output wr_en, output addr, output wdata);
endinterface

/* src/tif_flag_bank.sv */
// Sticky clear-on-read event flags, sixteen sources in two bytes
// Assumes events are one-cycle pulses synchronous to the clock
`timescale 1ns/1ps
`include "tif_regs.svh"
module tif_flag_bank
    import tif_pkg::*;
(
    input wire logic clk_in,                // Core clock
    input wire logic rst_n_in,              // Synchronised reset
    input wire logic soft_clear_in,         // Set-default clear
    tif_reg_if.bank reg_bus,                // Register access
    input wire tif_events_t events_in,      // Event pulses, high byte = reg 1
    output tif_events_t flags_out           // Current flags
);
    tif_events_t flags_q;
    tif_events_t flags_d;
    logic rd_low;
    logic rd_high;

    assign rd_low = reg_bus.rd_en && reg_bus.addr == `TIF_ADDR_FLAGS_LOW;
    assign rd_high = reg_bus.rd_en && reg_bus.addr == `TIF_ADDR_FLAGS_HIGH;

    // --------------------------------------------------------------
    // Flag update, set wins over read clear
    // --------------------------------------------------------------
    always_comb begin
        flags_d = flags_q;
        if (rd_low) begin
            flags_d[7:0] = `TIF_FLAGS_RESET;
        end
        if (rd_high) begin
            flags_d[15:8] = `TIF_FLAGS_RESET;
        end
        if (soft_clear_in) begin
            flags_d = {`TIF_FLAGS_RESET, `TIF_FLAGS_RESET};
        end
        flags_d = flags_d | events_in;
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            flags_q <= {`TIF_FLAGS_RESET, `TIF_FLAGS_RESET};
        end else begin
            flags_q <= flags_d;
        end
    end

    assign flags_out = flags_q;
endmodule

/* src/tif_event_ctrl.sv */
// Tag event flags, masks and interrupt line
// Assumes register accesses arrive as one-cycle strobes on the core clock
//
// Behaviour
// - Masks gate only the interrupt line
// - Masked events are still recorded
// - Masks load from stored configuration bytes
// - Reset or set-default clears both flag registers
// - Reading a flag register clears it
// - Power-up and listed commands set bit 7
// - Entering selected state sets wake-up flag
// - Reader sleep request sets sleep flag
// - Reader data write sets bit 4
// - Reader data read sets bit 3
// - Buffered reception end sets bit 2
// - Buffered transmission end sets bit 1
// - Buffered reception start sets high bit 7
// - Framing fault sets high bit 6
// - Parity fault sets high bit 5
// - Checksum mismatch sets high bit 4
// - Errors add to normal receive flags
// - Buffer over/underflow sets high bit 3
// - Host EEPROM write done sets high bit 2
// - Protected or missing address sets high bit 1
// - Access control abort sets high bit 0
`timescale 1ns/1ps
`include "tif_regs.svh"
module tif_event_ctrl
    import tif_pkg::*;
(
    input wire logic core_clk_in,               // 125 MHz core clock
    input wire logic resetn_in,                 // Async reset, active low
    input wire logic set_default_in,            // Set-default command pulse
    input wire logic mask_cfg_valid_in,         // Stored config bytes valid
    input wire logic [7:0] stored_mask_config_low_in,  // Default mask low
    input wire logic [7:0] stored_mask_config_high_in, // Default mask high
    input wire logic reg_rd_in,                 // Register read strobe
    input wire logic reg_wr_in,                 // Register write strobe
    input wire logic [7:0] reg_addr_in,         // Register address
    input wire logic [7:0] reg_wdata_in,        // Write data
    output logic [7:0] reg_rdata_out,           // Read data, registered
    input wire logic powerup_event_in,          // Power-up or field appears
    input wire logic mode_cmd_done_in,          // Sleep/sense/default done
    input wire logic selected_wakeup_event_in,  // Entered selected state
    input wire logic sleep_req_event_in,        // Reader sleep request
    input wire logic reader_wrote_data_event_in, // Reader updated data area
    input wire logic reader_read_data_event_in, // Reader read data area
    input wire logic rx_start_in,               // Reception start
    input wire logic rx_end_in,                 // Reception end
    input wire logic rx_to_buffer_in,           // Frame goes to buffer
    input wire logic tx_end_in,                 // Transmission end
    input wire logic tx_from_buffer_in,         // Response from buffer
    input wire logic field_exit_in,             // Field disappeared
    input wire logic framing_err_in,            // Broken byte or coding
    input wire logic parity_err_in,             // Parity fault
    input wire logic checksum_err_in,           // Checksum mismatch
    input wire logic buffer_fault_event_in,     // Overflow or underflow
    input wire logic host_eewr_done_in,         // Host EEPROM write done
    input wire logic ee_access_err_in,          // Protected/missing address
    input wire logic acc_abort_in,              // Access control abort
    output logic irq_out                        // Physical interrupt line
);
    logic rst_sync1_q;
    logic rst_sync2_q;
    logic rst_n;
    tif_load_t load_q;
    tif_byte_t mask_low_q;
    tif_byte_t mask_high_q;
    tif_events_t events;
    tif_events_t flags;
    logic irq_q;

    tif_reg_if reg_bus ();

    // ----------------------------------------------------------------
    // Reset release
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rst_sync1_q <= 1'b0;
            rst_sync2_q <= 1'b0;
        end else begin
            rst_sync1_q <= 1'b1;
            rst_sync2_q <= rst_sync1_q;
        end
    end
    assign rst_n = rst_sync2_q;

    function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] target);
        return a == target;
    endfunction

    // ----------------------------------------------------------------
    // Event sources
    // ----------------------------------------------------------------
    always_comb begin
        events = '0;
        events[`TIF_BIT_POWERUP] = powerup_event_in | mode_cmd_done_in | set_default_in;
        events[`TIF_BIT_WAKEUP] = selected_wakeup_event_in;
        events[`TIF_BIT_SLEEP] = sleep_req_event_in;
        events[`TIF_BIT_RD_WROTE] = reader_wrote_data_event_in;
        events[`TIF_BIT_RD_READ] = reader_read_data_event_in;
        events[`TIF_BIT_RX_END] = rx_end_in & rx_to_buffer_in;
        events[`TIF_BIT_TX_END] = tx_end_in & tx_from_buffer_in;
        events[`TIF_BIT_FIELD_EXIT] = field_exit_in;
        events[8 + `TIF_BIT_RX_START] = rx_start_in & rx_to_buffer_in;
        // Errors are independent of the normal receive flags
        events[8 + `TIF_BIT_FRAMING] = framing_err_in;
        events[8 + `TIF_BIT_PARITY] = parity_err_in;
        events[8 + `TIF_BIT_CHECKSUM] = checksum_err_in;
        events[8 + `TIF_BIT_BUF_FAULT] = buffer_fault_event_in;
        events[8 + `TIF_BIT_HOST_EEWR] = host_eewr_done_in;
        events[8 + `TIF_BIT_EE_ACCESS] = ee_access_err_in;
        events[8 + `TIF_BIT_ACC_ABORT] = acc_abort_in;
    end

    assign reg_bus.rd_en = reg_rd_in;
    assign reg_bus.wr_en = reg_wr_in;
    assign reg_bus.addr = reg_addr_in;
    assign reg_bus.wdata = reg_wdata_in;

    tif_flag_bank u_flags (
        .clk_in(core_clk_in),
        .rst_n_in(rst_n),
        .soft_clear_in(set_default_in),
        .reg_bus(reg_bus),
        .events_in(events),
        .flags_out(flags)
    );

    // ----------------------------------------------------------------
    // Masks, loaded from configuration after reset and each set-default, then host writable
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            load_q <= TIF_LOAD_WAIT;
        end else begin
            unique case (load_q)
                TIF_LOAD_WAIT: begin
                    if (mask_cfg_valid_in) begin
                        load_q <= TIF_LOAD_RUN;
                    end
                end
                TIF_LOAD_RUN: begin
                    if (set_default_in) begin
                        load_q <= TIF_LOAD_WAIT;
                    end
                end
                default: begin
                    load_q <= TIF_LOAD_WAIT;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            mask_low_q <= `TIF_MASK_RESET;
            mask_high_q <= `TIF_MASK_RESET;
        end else if (load_q == TIF_LOAD_WAIT) begin
            if (mask_cfg_valid_in) begin
                mask_low_q <= stored_mask_config_low_in;
                mask_high_q <= stored_mask_config_high_in;
            end
        end else if (reg_wr_in) begin
            if (addr_hit(reg_addr_in, `TIF_ADDR_MASK_LOW)) begin
                mask_low_q <= reg_wdata_in;
            end
            if (addr_hit(reg_addr_in, `TIF_ADDR_MASK_HIGH)) begin
                mask_high_q <= reg_wdata_in;
            end
        end
    end

    // ----------------------------------------------------------------
    // Read data
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_out <= 8'h00;
        end else if (reg_rd_in) begin
            if (addr_hit(reg_addr_in, `TIF_ADDR_MASK_LOW)) begin
                reg_rdata_out <= mask_low_q;
            end else if (addr_hit(reg_addr_in, `TIF_ADDR_MASK_HIGH)) begin
                reg_rdata_out <= mask_high_q;
            end else if (addr_hit(reg_addr_in, `TIF_ADDR_FLAGS_LOW)) begin
                reg_rdata_out <= flags[7:0];
            end else if (addr_hit(reg_addr_in, `TIF_ADDR_FLAGS_HIGH)) begin
                reg_rdata_out <= flags[15:8];
            end else begin
                reg_rdata_out <= 8'h00;
            end
        end
    end

    // ----------------------------------------------------------------
    // Interrupt line
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(flags & ~{mask_high_q, mask_low_q});
        end
    end
    assign irq_out = irq_q;
endmodule

/* tb/tif_event_ctrl_sva.sv */
// Port-level assertions for the tag event block
// Assumes one core clock and an async active-low reset
`timescale 1ns/1ps
`include "tif_regs.svh"
module tif_event_ctrl_sva (
    input wire logic core_clk_in, // Clock
    input wire logic resetn_in, // Reset
    input wire logic set_default_in, // Set-default
    input wire logic mask_cfg_valid_in, // Config valid
    input wire logic reg_rd_in, // Read
    input wire logic reg_wr_in, // Write
    input wire logic [7:0] reg_addr_in, // Address
    input wire logic [7:0] reg_wdata_in, // Write data
    input wire logic [7:0] reg_rdata_out, // Read data
    input wire logic powerup_event_in, // Power-up
    input wire logic field_exit_in, // Field exit
    input wire logic acc_abort_in, // Abort
    input wire logic irq_out // Interrupt
);
// ------------------------------------------------
// Settle counter and properties
// ------------------------------------------------
    logic [1:0] up_q;
    wire logic ok = (up_q == 2'h3);
    wire logic rd_lo = reg_rd_in && (reg_addr_in == `TIF_ADDR_FLAGS_LOW);
    wire logic rd_hi = reg_rd_in && (reg_addr_in == `TIF_ADDR_FLAGS_HIGH);
    wire logic ml = (reg_addr_in == `TIF_ADDR_MASK_LOW);
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            up_q <= 2'h0;
        end else if (!ok) begin
            up_q <= up_q + 2'h1;
        end
    end
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!resetn_in);
    exit_flag_a: assert property (ok && $past(field_exit_in) && rd_lo |=> reg_rdata_out[0])
        else $error("exit flag missing");
    read_clear_a: assert property (ok && rd_lo && !field_exit_in ##1 rd_lo && !field_exit_in
        |=> !reg_rdata_out[0]) else $error("flag survived read");
    abort_flag_a: assert property (ok && $past(acc_abort_in) && rd_hi |=> reg_rdata_out[0])
        else $error("abort flag missing");
    powerup_flag_a: assert property (ok && $past(powerup_event_in) && rd_lo
        |=> reg_rdata_out[7]) else $error("power-up flag missing");
    default_flag_a: assert property (ok && set_default_in ##1 rd_lo |=> reg_rdata_out[7])
        else $error("set-default flag missing");
    default_clear_a: assert property (ok && set_default_in && !field_exit_in
        ##1 rd_lo && !field_exit_in |=> !reg_rdata_out[0]) else $error("flags not cleared");
    mask_rw_a: assert property (ok && $past(mask_cfg_valid_in) && !$past(set_default_in)
        && !set_default_in && reg_wr_in && ml ##1 !reg_wr_in ##1 reg_rd_in && ml
        |=> reg_rdata_out == $past(reg_wdata_in, 3)) else $error("mask readback wrong");
    irq_fall_a: assert property (ok && $fell(irq_out) |-> $past(reg_rd_in, 2)
        || $past(reg_wr_in, 2) || $past(set_default_in, 2) || $past(set_default_in, 3)
        || ($past(mask_cfg_valid_in, 2) && !$past(mask_cfg_valid_in, 3)))
        else $error("interrupt dropped without cause");
    cover property (ok && $rose(irq_out));
    cover property (ok && set_default_in);
    cover property (ok && rd_lo ##1 rd_lo);
endmodule

bind tif_event_ctrl tif_event_ctrl_sva chk_i (.core_clk_in(core_clk_in), .resetn_in(resetn_in),
    .set_default_in(set_default_in), .mask_cfg_valid_in(mask_cfg_valid_in),
    .reg_rd_in(reg_rd_in), .reg_wr_in(reg_wr_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
    .powerup_event_in(powerup_event_in), .field_exit_in(field_exit_in),
    .acc_abort_in(acc_abort_in), .irq_out(irq_out));

/* tb/tif_host_model.sv */
// Host register master for the tag event block
// Assumes every task is entered just after a rising clock edge
`timescale 1ns/1ps
module tif_host_model (
    input wire logic clk_in, // Clock
    input wire logic [7:0] rdata_in, // Read data
    output logic rd_out, // Read strobe
    output logic wr_out, // Write strobe
    output logic [7:0] addr_out, // Address
    output logic [7:0] wdata_out // Write data
);
// ------------------------------------------------
// Bus tasks; released lines show inverted values
// ------------------------------------------------
    initial begin
        rd_out = 1'h0;
        wr_out = 1'h0;
        addr_out = 8'h00;
        wdata_out = 8'h00;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        wr_out <= 1'h1;
        addr_out <= a;
        wdata_out <= d;
        @(posedge clk_in);
        wr_out <= 1'h0;
        addr_out <= ~a;
        wdata_out <= ~d;
        @(posedge clk_in);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] b, input logic two,
        output logic [7:0] d);
        rd_out <= 1'h1;
        addr_out <= a;
        @(posedge clk_in);
        if (two) begin
            addr_out <= b;
            @(posedge clk_in);
        end
        rd_out <= 1'h0;
        addr_out <= ~b;
        @(negedge clk_in);
        d = rdata_in;
        @(posedge clk_in);
    endtask
endmodule

/* tb/tif_event_ctrl_bench.sv */
// Self-checking bench for the tag event block
// Assumes the host model drives all register accesses
`timescale 1ns/1ps
module tif_event_ctrl_bench;
// ------------------------------------------------
// Stimulus, instances and scenarios
// ------------------------------------------------
    localparam logic [7:0] LO = 8'h0A;
    localparam logic [7:0] HI = 8'h0B;
    localparam logic [7:0] ML = 8'h08;
    logic clk, rstn, sdef, qual, cfg, rd, wr, irq;
    logic [7:0] addr, wdata, rdata, got;
    logic [16:0] ev;
    int mismatches, cmp_count;
    initial begin
        clk = 1'h0;
        forever #4 clk = ~clk;
    end
    tif_host_model host (.clk_in(clk), .rdata_in(rdata), .rd_out(rd), .wr_out(wr),
        .addr_out(addr), .wdata_out(wdata));
    tif_event_ctrl dut (.core_clk_in(clk), .resetn_in(rstn), .set_default_in(sdef),
        .mask_cfg_valid_in(cfg), .stored_mask_config_low_in(8'hFE),
        .stored_mask_config_high_in(8'hFF), .reg_rd_in(rd), .reg_wr_in(wr),
        .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
        .powerup_event_in(ev[7]), .mode_cmd_done_in(ev[16]), .selected_wakeup_event_in(ev[6]),
        .sleep_req_event_in(ev[5]), .reader_wrote_data_event_in(ev[4]),
        .reader_read_data_event_in(ev[3]), .rx_start_in(ev[15]), .rx_end_in(ev[2]),
        .rx_to_buffer_in(qual), .tx_end_in(ev[1]), .tx_from_buffer_in(qual),
        .field_exit_in(ev[0]), .framing_err_in(ev[14]), .parity_err_in(ev[13]),
        .checksum_err_in(ev[12]), .buffer_fault_event_in(ev[11]), .host_eewr_done_in(ev[10]),
        .ee_access_err_in(ev[9]), .acc_abort_in(ev[8]), .irq_out(irq));
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic fire(input logic [16:0] m);
        ev <= m;
        @(posedge clk);
        ev <= 17'h0_0000;
    endtask
    task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
        host.rd(a, a, 1'h0, got);
        chk(what, got, exp);
    endtask
    task automatic irq_chk(input logic exp);
        @(posedge clk);
        @(negedge clk);
        chk("irq", {7'h00, irq}, {7'h00, exp});
        @(posedge clk);
    endtask
    task automatic t_sources();
        logic [7:0] a;
        logic [7:0] e;
        for (int i = 0; i < 17; i++) begin
            a = (i % 16 < 8) ? LO : HI;
            e = 8'h01 << ((i == 16) ? 7 : i % 8);
            fire(17'h0_0001 << i);
            rd_chk("flag", a, e);
        end
        qual <= 1'h0;
        fire(17'h0_8006);
        rd_chk("unbuffered", LO, 8'h00);
        rd_chk("unbuffered", HI, 8'h00);
        qual <= 1'h1;
        $display("sources test done");
    endtask
    task automatic t_errors();
        fire(17'h0_F004);
        rd_chk("error flags", HI, 8'hF0);
        rd_chk("receive end", LO, 8'h04);
        fire(17'h0_0001);
        host.rd(LO, LO, 1'h1, got);
        chk("second read", got, 8'h00);
        irq_chk(1'h0);
        $display("errors test done");
    endtask
    task automatic t_mask();
        fire(17'h0_0080);
        irq_chk(1'h0);
        host.wr(ML, 8'h7F);
        rd_chk("mask low", ML, 8'h7F);
        irq_chk(1'h1);
        rd_chk("masked flag", LO, 8'h80);
        irq_chk(1'h0);
        host.wr(8'h09, 8'h00);
        fire(17'h0_0100);
        irq_chk(1'h1);
        rd_chk("abort", HI, 8'h01);
        $display("mask test done");
    endtask
    task automatic t_default();
        fire(17'h0_0101);
        cfg <= 1'h0;
        sdef <= 1'h1;
        @(posedge clk);
        sdef <= 1'h0;
        rd_chk("default low", LO, 8'h80);
        // Write while the reload is pending must be dropped
        host.wr(ML, 8'h00);
        cfg <= 1'h1;
        rd_chk("default high", HI, 8'h00);
        rd_chk("mask low", ML, 8'hFE);
        rd_chk("mask high", 8'h09, 8'hFF);
        rd_chk("unmapped", 8'h0C, 8'h00);
        $display("default test done");
    endtask
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        rstn = 1'h0;
        sdef = 1'h0;
        qual = 1'h1;
        cfg = 1'h1;
        ev = 17'h0_0000;
        repeat (4) @(posedge clk);
        rstn <= 1'h1;
        repeat (3) @(posedge clk);
        t_default();
        t_sources();
        t_errors();
        t_mask();
        t_default();
        test_done();
    end
    initial begin
        #100000;
        mismatches++;
        test_done();
    end
endmodule
